// ---- rtl/ready_ctrl.sv ----
// ready-controlled bus cycle sequencer with wait-state insertion
`timescale 1ns/10ps
// Overview of operation
// - ready active level chosen by a polarity input, high or low
// - async mode: ready goes through extra sync stage, at least one wait
// - first ready sample point placed after programmed access phase length
// - ready inactive at sample point inserts a wait phase, resample next
// - ready active at sample point ends the running bus cycle
// - sample points differ per mode; ready ignored during access phase
// - read data captured on the edge that raises the read strobe
module ready_ctrl import rdy_pkg::*; #(
	parameter int DW = DATA_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire cyc_req_t req,
	input wire logic ready_active_high,
	input wire logic ready_async_mode,
	input wire logic ready_pin,
	input wire logic [DW-1:0] data_pin,
	output logic rd_n,
	output logic wr_n,
	output logic cyc_busy,
	output logic cyc_done,
	output logic [DW-1:0] rd_data,
	output logic [5:0] wait_count,
	output logic bus_reference_clock_out
);
	typedef struct packed {
		cyc_state_t state;
		logic is_read;
		logic rdy_ctl;
		logic async_m;
		logic pol_hi;
		logic [5:0] acc_cnt;
		logic [1:0] skip_cnt;
		logic [5:0] wait_cnt;
		logic rdy_reg;
		logic raw_s1;
		logic raw_s2;
		logic [DW-1:0] data_s1;
		logic [DW-1:0] data_s2;
		logic [DW-1:0] rdata;
		bus_strobe_t strb;
		logic done;
		logic ref_clk;
	} ctl_st_t;

	ctl_st_t st_q;
	ctl_st_t st_d;
	logic rdy_synced;
	logic rdy_sample;
	logic rdy_seen;

	// async path: two-flop synchroniser, and
	rdy_sync u_async_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(ready_pin),
		.sync_out(rdy_synced)
	);

	// async mode reads the extra registered stage, adding a wait
	assign rdy_sample = st_q.async_m ? st_q.rdy_reg : st_q.raw_s2;
	// polarity applied after synchronisation
	assign rdy_seen = st_q.pol_hi ? rdy_sample : ~rdy_sample;

	// sequencer next state
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.ref_clk = ~st_q.ref_clk;
		st_d.rdy_reg = rdy_synced; // extra async stage
		// sync path: two pin flops, the first read only by the second
		st_d.raw_s1 = ready_pin;
		st_d.raw_s2 = st_q.raw_s1;
		st_d.data_s1 = data_pin;
		st_d.data_s2 = st_q.data_s1;
		unique case (st_q.state)
			ST_IDLE: begin
				st_d.strb = '{rd_n: 1'b1, wr_n: 1'b1, busy: 1'b0};
				if (req.start) begin
					st_d.state = ST_ACC;
					st_d.is_read = req.is_read;
					st_d.rdy_ctl = req.rdy_ctl;
					// mode and polarity latched per cycle so a change mid-cycle is harmless
					st_d.async_m = ready_async_mode;
					st_d.pol_hi = ready_active_high;
					// access phase length clamped to 1..32
					if (req.acc_len < ACC_MIN) begin
						st_d.acc_cnt = ACC_MIN;
					end else if (req.acc_len > ACC_MAX) begin
						st_d.acc_cnt = ACC_MAX;
					end else begin
						st_d.acc_cnt = req.acc_len;
					end
					st_d.skip_cnt = ready_async_mode ? ASYNC_EXTRA : 2'h0;
					st_d.wait_cnt = 6'h00;
					st_d.strb = '{rd_n: ~req.is_read, wr_n: req.is_read, busy: 1'b1};
				end
			end
			ST_ACC: begin
				// ready ignored until mandatory access waits elapse
				st_d.acc_cnt = st_q.acc_cnt - 6'h01;
				if (st_q.acc_cnt == 6'h01) begin
					st_d.state = st_q.rdy_ctl ? ST_RDYW : ST_END;
				end
			end
			ST_RDYW: begin
				if (st_q.skip_cnt != 2'h0) begin
					// async: forced wait for the extra stage
					st_d.skip_cnt = st_q.skip_cnt - 2'h1;
					st_d.wait_cnt = st_q.wait_cnt + 6'h01;
				end else if (rdy_seen) begin
					st_d.state = ST_END;
				end else begin
					// inactive: one more wait phase
					st_d.wait_cnt = st_q.wait_cnt + 6'h01;
				end
			end
			ST_END: begin
				// strobe rises and read data captured on the same edge
				st_d.strb = '{rd_n: 1'b1, wr_n: 1'b1, busy: 1'b0};
				if (st_q.is_read) begin
					st_d.rdata = st_q.data_s2;
				end
				st_d.done = 1'b1;
				st_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= '{state: ST_IDLE, is_read: 1'b0, rdy_ctl: 1'b0, async_m: 1'b0, pol_hi: 1'b1,
				acc_cnt: 6'h00, skip_cnt: 2'h0, wait_cnt: 6'h00, rdy_reg: 1'b0, raw_s1: 1'b0, raw_s2: 1'b0,
				data_s1: '0, data_s2: '0, rdata: '0,
				strb: '{rd_n: 1'b1, wr_n: 1'b1, busy: 1'b0}, done: 1'b0, ref_clk: REF_CLK_RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_n = st_q.strb.rd_n;
	assign wr_n = st_q.strb.wr_n;
	assign cyc_busy = st_q.strb.busy;
	assign cyc_done = st_q.done;
	assign rd_data = st_q.rdata;
	assign wait_count = st_q.wait_cnt;
	assign bus_reference_clock_out = st_q.ref_clk;

	// while the access phase counts down the sequencer stays there and ignores ready
	chk_acc_no_sample: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_ACC && st_q.acc_cnt != 6'h01) |=> st_q.state == ST_ACC)
		else $error("access phase left before its programmed length");

	// inactive ready at a sample point costs exactly one more wait phase
	chk_rdy_wait_extend: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_RDYW && st_q.skip_cnt == 2'h0 && !rdy_seen) |=> (st_q.state == ST_RDYW
		&& st_q.wait_cnt == $past(st_q.wait_cnt) + 6'h01))
		else $error("inactive ready did not add a wait phase");

	// active ready ends the cycle through the end phase
	chk_rdy_ends_cycle: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_RDYW && st_q.skip_cnt == 2'h0 && rdy_seen) |=> ##1 (cyc_done && !cyc_busy))
		else $error("active ready did not end cycle");

	// async forced wait holds the cycle even when ready is already active
	chk_async_extra_wait: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_RDYW && st_q.skip_cnt != 2'h0) |=> (st_q.state == ST_RDYW
		&& st_q.wait_cnt == $past(st_q.wait_cnt) + 6'h01))
		else $error("async forced wait skipped");

	// async ready cycles always report at least one wait
	chk_async_min_wait: assert property (@(posedge core_clk) disable iff (rst)
		(cyc_done && st_q.async_m && st_q.rdy_ctl) |-> (wait_count >= 6'h01))
		else $error("async ready cycle without wait state");

	// read data taken on the edge that raises the read strobe
	chk_read_capture: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_END && st_q.is_read) |=> (rd_n && rd_data == $past(st_q.data_s2)))
		else $error("read data not captured with strobe rise");

	// strobes released with done, and done lasts a single cycle
	chk_done_release: assert property (@(posedge core_clk) disable iff (rst)
		cyc_done |-> (rd_n && wr_n && !cyc_busy) ##1 !cyc_done)
		else $error("done pulse too long or strobe still low");

	// a new cycle starts its strobe with a clamped access length
	chk_strobe_active: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_IDLE && req.start) |=> (cyc_busy && (rd_n != wr_n) && st_q.acc_cnt >= ACC_MIN))
		else $error("strobe or access length wrong at start");

	// wait count restarts with every cycle, so no old count leaks into the next
	chk_wait_restart: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_IDLE && req.start) |=> wait_count == 6'h00)
		else $error("wait count not cleared at cycle start");

	// ready at its chosen active level ends the wait, for either polarity
	chk_polarity: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_RDYW && st_q.skip_cnt == 2'h0 && rdy_sample == st_q.pol_hi) |=> st_q.state == ST_END)
		else $error("ready polarity not applied");

	// cycles without ready control never wait for ready
	chk_no_ready_uncontrolled: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == ST_ACC && st_q.acc_cnt == 6'h01 && !st_q.rdy_ctl) |=> st_q.state == ST_END)
		else $error("uncontrolled cycle entered ready wait");

	// reference clock toggles every edge, the first edge after reset included; that first toggle is checked one edge later
	chk_ref_clk_toggle: assert property (@(posedge core_clk) disable iff (rst)
		!$past(rst) |-> bus_reference_clock_out != $past(bus_reference_clock_out))
		else $error("reference clock did not toggle");

	// main scenarios: both modes, low polarity, long waits
	cov_sync_read: cover property (@(posedge core_clk) cyc_done && !st_q.async_m && st_q.is_read);
	cov_async_write: cover property (@(posedge core_clk) cyc_done && st_q.async_m && !st_q.is_read);
	cov_long_wait: cover property (@(posedge core_clk) cyc_done && wait_count > 6'h03);
	cov_low_polarity: cover property (@(posedge core_clk) cyc_done && !st_q.pol_hi && st_q.rdy_ctl);
endmodule

// ---- pkg/rdy_pkg.sv ----
// shared types and constants of the ready wait-state controller
package rdy_pkg;
	// phase counters are 6 bits wide, access phase spans 1..32
	localparam int PHASE_W = 6;
	localparam logic [5:0] ACC_MIN = 6'h01;
	localparam logic [5:0] ACC_MAX = 6'h20;
	localparam int DATA_W = 16;
	localparam logic SYNC_FF_RST = 1'b0;
	localparam logic REF_CLK_RST = 1'b0;
	// async mode: extra sample stage before the ready value is used
	localparam logic [1:0] ASYNC_EXTRA = 2'h1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACC = 2'b01,
		ST_RDYW = 2'b10,
		ST_END = 2'b11
	} cyc_state_t;

	// one bus cycle request from the core
	typedef struct packed {
		logic start;
		logic is_read;
		logic rdy_ctl;
		logic [5:0] acc_len;
	} cyc_req_t;

	// strobes driven to the pins
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic busy;
	} bus_strobe_t;
endpackage

// ---- rtl/rdy_sync.sv ----
// two-flop synchroniser for the ready pin
`timescale 1ns/10ps
module rdy_sync import rdy_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_st_t;

	sync_st_t st_q;
	sync_st_t st_d;

	// first stage is read only by the second
	always_comb begin
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= '{s1: SYNC_FF_RST, s2: SYNC_FF_RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule

// ---- tb/ready_partner.sv ----
// external circuit model: answers ready after a set delay and drives read data
`timescale 1ns/10ps
module ready_partner (
	input wire logic core_clk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic active_high,
	input wire logic [7:0] delay,
	input wire logic [15:0] rd_value,
	output logic ready_pin,
	output logic [15:0] data_pin
);
	logic [7:0] low_cnt = 8'h00;
	logic act = 1'b0;
	// ready follows the strobe, launched just after the reference edge
	always @(posedge core_clk) begin
		#1;
		low_cnt = (!rd_n || !wr_n) ? low_cnt + 8'h01 : 8'h00;
		// held until the ending strobe rises, well over one period plus setup
		// dropped at once on the strobe's rising edge, before the next cycle samples
		act = (low_cnt != 8'h00) && (low_cnt > delay);
		ready_pin = active_high ? act : !act;
		// released bus shows the inverse, so stale data never looks valid
		data_pin = !rd_n ? rd_value : ~rd_value;
	end
endmodule

// ---- tb/ready_ctrl_tb.sv ----
// self-checking bench for the ready-controlled bus cycle sequencer
`timescale 1ns/10ps
module ready_ctrl_tb import rdy_pkg::*;;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	cyc_req_t req = '0;
	logic ah = 1'b1;
	logic am = 1'b0;
	logic [7:0] dly = 8'h00;
	logic [15:0] val = 16'hA5C3;
	logic ready_pin, rd_n, wr_n, cyc_busy, cyc_done, bus_reference_clock_out;
	logic [15:0] data_pin, rd_data;
	logic [5:0] wait_count;
	int n_mismatch = 0;
	int total_checks = 0;
	int len, wc, wc0;
	always #5 core_clk = ~core_clk;
	ready_ctrl ready_ctrl_inst (.core_clk(core_clk), .rst(rst), .req(req), .ready_active_high(ah),
		.ready_async_mode(am), .ready_pin(ready_pin), .data_pin(data_pin), .rd_n(rd_n), .wr_n(wr_n),
		.cyc_busy(cyc_busy), .cyc_done(cyc_done), .rd_data(rd_data), .wait_count(wait_count),
		.bus_reference_clock_out(bus_reference_clock_out));
	ready_partner ready_partner_inst (.core_clk(core_clk), .rd_n(rd_n), .wr_n(wr_n), .active_high(ah),
		.delay(dly), .rd_value(val), .ready_pin(ready_pin), .data_pin(data_pin));
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus cycle; length counted from the take edge to the done pulse
	task automatic run_cyc(input logic rd, input logic ctl, input logic [5:0] acc);
		req = '{start: 1'b1, is_read: rd, rdy_ctl: ctl, acc_len: acc};
		@(posedge core_clk);
		#1 req.start = 1'b0;
		chk({cyc_busy, rd_n, wr_n}, {1'b1, ~rd, rd});
		len = 0;
		while (cyc_done !== 1'b1) begin
			@(posedge core_clk);
			#1 len++;
			if (len > 200) begin
				n_mismatch++;
				conclude();
			end
		end
		wc = wait_count;
		chk({cyc_busy, rd_n, wr_n}, 3'h3);
	endtask
	// uncontrolled cycles: length set by the access phase alone, read data captured at end
	task automatic t_plain();
		val = 16'hA5C3;
		run_cyc(1'b1, 1'b0, 6'h04);
		chk(16'(len), 16'h0005);
		chk(rd_data, 16'hA5C3);
		run_cyc(1'b0, 1'b0, ACC_MIN);
		chk(16'(len), 16'h0002);
		run_cyc(1'b0, 1'b0, ACC_MAX);
		chk(16'(len), 16'h0021);
	endtask
	// sync ready: prompt, then late, both polarities
	task automatic t_sync();
		am = 1'b0;
		dly = 8'h00;
		val = 16'h3C5A;
		run_cyc(1'b1, 1'b1, 6'h04);
		wc0 = wc;
		chk(16'(len), 16'(6 + wc));
		chk(rd_data, 16'h3C5A);
		dly = 8'h09;
		run_cyc(1'b1, 1'b1, 6'h04);
		chk(16'(wc > wc0), 16'h0001);
		chk(16'(len), 16'(6 + wc));
		ah = 1'b0;
		dly = 8'h00;
		run_cyc(1'b0, 1'b1, 6'h04);
		chk(16'(wc), 16'(wc0));
		ah = 1'b1;
	endtask
	// async ready: at least one more wait than sync with the same prompt answer
	task automatic t_async();
		am = 1'b1;
		dly = 8'h00;
		run_cyc(1'b0, 1'b1, 6'h02);
		chk(16'(wc >= 1), 16'h0001);
		chk(16'(wc > wc0), 16'h0001);
		chk(16'(len), 16'(4 + wc));
		am = 1'b0;
	endtask
	// reset in mid-cycle aborts it; afterwards out-of-range access lengths are clamped
	task automatic t_reset();
		req = '{start: 1'b1, is_read: 1'b1, rdy_ctl: 1'b1, acc_len: 6'h08};
		@(posedge core_clk);
		#1 req.start = 1'b0;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk({rd_n, wr_n, cyc_busy, cyc_done}, 4'hC);
		chk(rd_data, 16'h0000);
		chk(16'(bus_reference_clock_out), 16'h0000);
		rst = 1'b0;
		@(posedge core_clk);
		#1 chk(16'(bus_reference_clock_out), 16'h0001);
		run_cyc(1'b0, 1'b0, 6'h00);
		chk(16'(len), 16'h0002);
		run_cyc(1'b0, 1'b0, 6'h3F);
		chk(16'(len), 16'h0021);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		#1 rst = 1'b0;
		t_plain();
		t_sync();
		t_async();
		t_reset();
		conclude();
	end
endmodule
